// File: hbc_pkg.sv
// Constants and carriers for the H-bridge control and SPI diagnosis block.
// Assumes a 25 MHz system clock; the SPI side runs on the master's clock.
package hbc_pkg;

    localparam int unsigned MCLK_HZ = 25_000_000;
    localparam int unsigned MCLK_PER_US = MCLK_HZ / 1_000_000;

    // Off time after the current limit is reached, in ns.
    localparam int unsigned CL_OFF_NS = 100_000;
    localparam int unsigned CL_OFF_CYC_I = (CL_OFF_NS * MCLK_PER_US + 999) / 1000;
    localparam logic [11:0] CL_OFF_CYC = CL_OFF_CYC_I[11:0];

    // Internal processing time after a frame ends, in ns.
    localparam int unsigned PROC_NS = 200;
    localparam int unsigned PROC_CYC_I = (PROC_NS * MCLK_PER_US + 999) / 1000;
    localparam logic [3:0] PROC_CYC = PROC_CYC_I[3:0];

    localparam logic [4:0] FRAME_BITS = 5'h10;
    localparam logic [4:0] COUNT_MAX = 5'h1F;
    localparam logic [4:0] IDX_ADDR_DONE = 5'h02;
    localparam logic [4:0] IDX_CHECK_LAST = 5'h07;
    localparam logic [4:0] IDX_DATA_FIRST = 5'h08;
    localparam logic [1:0] CHIP_ADDR = 2'h0;

    localparam logic [4:0] INS_IDENT = 5'h00;
    localparam logic [4:0] INS_VERSION = 5'h01;
    localparam logic [4:0] INS_DIAG = 5'h04;

    localparam logic [4:0] CHECK_PATTERN = 5'h15;
    localparam logic [7:0] DATA_UNUSED = 8'hFF;
    localparam logic [7:0] DIAG_RESET = 8'hFF;
    localparam int unsigned DIAG_EN_BIT = 7;
    localparam int unsigned DIAG_OT_BIT = 6;
    localparam int unsigned DIAG_CRED_BIT = 5;
    localparam int unsigned DIAG_CLIM_BIT = 4;

    // Pin levels that enter the system clock domain.
    typedef struct packed {
        logic ss_n;
        logic mode_select_supply_pin;
        logic bridge_off_input;
        logic enable;
        logic drive_a_input;
        logic drive_b_input;
        logic off_float;
        logic en_float;
        logic short_fault;
        logic over_current;
        logic over_temp;
        logic under_volt;
        logic curr_limit;
        logic curr_reduce;
        logic neg_leg_a;
        logic neg_leg_b;
        logic [3:0] leg_diag;
    } hbc_pins_t;

    // Frame state captured on the SPI clock, read after the frame.
    typedef struct packed {
        logic addr_ok;
        logic [4:0] count;
        logic [15:0] word;
    } hbc_frame_t;

endpackage

// File: hbc_bridge.sv
// H-bridge control, fault handling and SPI slave for diagnosis.
// Assumes fault levels come from analogue comparators and the SPI master
// keeps SCK idle low outside frames.
`timescale 1ns/10ps
`default_nettype none

module hbc_bridge
    import hbc_pkg::*;
#(
    // Identification values are arbitrary.
    parameter logic [7:0] IDENT_CODE = 8'h5A,
    parameter logic [7:0] VERSION_CODE = 8'h01
) (
    input wire logic i_mclk,
    input wire logic i_resetn,
    input wire logic i_sck,
    input wire logic i_ss_n,
    input wire logic i_si,
    input wire logic i_mode_select_supply_pin,
    input wire logic i_bridge_off_input,
    input wire logic i_enable,
    input wire logic i_drive_a_input,
    input wire logic i_drive_b_input,
    input wire logic i_off_float,
    input wire logic i_en_float,
    input wire logic i_short_fault,
    input wire logic i_over_current,
    input wire logic i_over_temp,
    input wire logic i_under_volt,
    input wire logic i_curr_limit,
    input wire logic i_curr_reduce,
    input wire logic i_neg_leg_a,
    input wire logic i_neg_leg_b,
    input wire logic [3:0] i_leg_diag,
    output logic o_so,
    output logic o_so_oe,
    output logic o_fault_flag_pin,
    output logic o_fault_flag_pin_oe,
    output logic o_bridge_leg_a,
    output logic o_bridge_leg_a_oe,
    output logic o_bridge_leg_b,
    output logic o_bridge_leg_b_oe
);

    function automatic logic code_used(input logic [4:0] code);
        code_used = (code == INS_IDENT) || (code == INS_VERSION) || (code == INS_DIAG);
    endfunction

    // SPI clock domain.
    // Mode pin reset
    logic spi_rst_n;
    logic frame_rst_n;
    assign spi_rst_n = i_resetn & i_mode_select_supply_pin;
    assign frame_rst_n = spi_rst_n & ~i_ss_n;

    logic started_ff;
    hbc_frame_t frame_ff;
    logic [7:0] tx_ff;
    logic so_ff;
    logic so_oe_ff;
    logic err_meta_ff;
    logic err_sync_ff;
    logic [7:0] diag_hold_ff;
    logic prev_err_ff;

    always_ff @(negedge i_sck or negedge frame_rst_n) begin
        if (!frame_rst_n) begin
            started_ff <= 1'b0;
        end else begin
            started_ff <= 1'b1;
        end
    end

    always_ff @(negedge i_sck or negedge spi_rst_n) begin
        if (!spi_rst_n) begin
            frame_ff <= '0;
        end else if (!started_ff) begin
            frame_ff.count <= 5'h01;
            frame_ff.word <= {15'h0000, i_si};
            frame_ff.addr_ok <= 1'b0;
        end else begin
            if (frame_ff.count != COUNT_MAX) begin
                frame_ff.count <= frame_ff.count + 5'h01;
            end
            frame_ff.word <= {frame_ff.word[14:0], i_si};
            if (frame_ff.count == 5'h01) begin
                frame_ff.addr_ok <= ({frame_ff.word[0], i_si} == CHIP_ADDR);
            end
        end
    end

    always_ff @(posedge i_sck or negedge spi_rst_n) begin
        if (!spi_rst_n) begin
            err_meta_ff <= 1'b0;
            err_sync_ff <= 1'b0;
        end else begin
            err_meta_ff <= prev_err_ff;
            err_sync_ff <= err_meta_ff;
        end
    end

    logic [4:0] tx_idx;
    logic [7:0] check_byte;
    logic [7:0] data_byte;
    assign tx_idx = started_ff ? frame_ff.count : 5'h00;
    assign check_byte = {2'b00, CHECK_PATTERN, err_sync_ff};

    always_comb begin
        case (frame_ff.word[5:1])
            INS_IDENT: data_byte = IDENT_CODE;
            INS_VERSION: data_byte = VERSION_CODE;
            INS_DIAG: data_byte = diag_hold_ff;
            default: data_byte = DATA_UNUSED;
        endcase
    end

    always_ff @(posedge i_sck or negedge frame_rst_n) begin
        if (!frame_rst_n) begin
            so_ff <= 1'b0;
            so_oe_ff <= 1'b0;
            tx_ff <= 8'h00;
        end else if (tx_idx < IDX_ADDR_DONE) begin
            so_ff <= 1'b0;
            so_oe_ff <= 1'b0;
        end else if (tx_idx <= IDX_CHECK_LAST) begin
            so_ff <= check_byte[3'h7 - tx_idx[2:0]];
            so_oe_ff <= frame_ff.addr_ok;
        end else if (tx_idx == IDX_DATA_FIRST) begin
            so_ff <= data_byte[7];
            tx_ff <= {data_byte[6:0], 1'b1};
            so_oe_ff <= frame_ff.addr_ok;
        end else begin
            so_ff <= tx_ff[7];
            tx_ff <= {tx_ff[6:0], 1'b1};
            so_oe_ff <= frame_ff.addr_ok;
        end
    end

    assign o_so = so_ff;
    assign o_so_oe = so_oe_ff;

    // System clock domain.
    hbc_pins_t pins_raw;
    hbc_pins_t pins_meta_ff;
    hbc_pins_t pins_ff;
    hbc_pins_t pins_d_ff;
    assign pins_raw = '{ss_n: i_ss_n, mode_select_supply_pin: i_mode_select_supply_pin,
                        bridge_off_input: i_bridge_off_input, enable: i_enable,
                        drive_a_input: i_drive_a_input, drive_b_input: i_drive_b_input,
                        off_float: i_off_float, en_float: i_en_float,
                        short_fault: i_short_fault, over_current: i_over_current,
                        over_temp: i_over_temp, under_volt: i_under_volt,
                        curr_limit: i_curr_limit, curr_reduce: i_curr_reduce,
                        neg_leg_a: i_neg_leg_a, neg_leg_b: i_neg_leg_b, leg_diag: i_leg_diag};

    // Disable high and enable low are the safe idle levels.
    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            pins_meta_ff <= '{ss_n: 1'b1, bridge_off_input: 1'b1, default: '0};
            pins_ff <= '{ss_n: 1'b1, bridge_off_input: 1'b1, default: '0};
            pins_d_ff <= '{ss_n: 1'b1, bridge_off_input: 1'b1, default: '0};
        end else begin
            pins_meta_ff <= pins_raw;
            pins_ff <= pins_meta_ff;
            pins_d_ff <= pins_ff;
        end
    end

    logic off_req;
    logic hard_fault;
    logic fault_clear;
    logic latch_ff;
    logic [11:0] cl_cnt_ff;
    logic bridge_on;

    assign off_req = pins_ff.bridge_off_input | ~pins_ff.enable | pins_ff.off_float | pins_ff.en_float;
    assign hard_fault = pins_ff.short_fault | pins_ff.over_current | pins_ff.over_temp;
    assign fault_clear = (pins_d_ff.bridge_off_input & ~pins_ff.bridge_off_input) |
                         (~pins_d_ff.enable & pins_ff.enable);

    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            latch_ff <= 1'b0;
        end else if (hard_fault) begin
            latch_ff <= 1'b1;
        end else if (fault_clear) begin
            latch_ff <= 1'b0;
        end
    end

    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            cl_cnt_ff <= 12'h000;
        end else if (pins_ff.curr_limit && cl_cnt_ff == 12'h000) begin
            cl_cnt_ff <= CL_OFF_CYC;
        end else if (cl_cnt_ff != 12'h000) begin
            cl_cnt_ff <= cl_cnt_ff - 12'h001;
        end
    end

    assign bridge_on = ~off_req & ~latch_ff & ~hard_fault & ~pins_ff.under_volt &
                       ~pins_ff.curr_limit & (cl_cnt_ff == 12'h000);

    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_bridge_leg_a <= 1'b0;
            o_bridge_leg_a_oe <= 1'b0;
            o_bridge_leg_b <= 1'b0;
            o_bridge_leg_b_oe <= 1'b0;
        end else if (bridge_on) begin
            o_bridge_leg_a <= pins_ff.drive_a_input;
            o_bridge_leg_a_oe <= 1'b1;
            o_bridge_leg_b <= pins_ff.drive_b_input;
            o_bridge_leg_b_oe <= 1'b1;
        end else begin
            o_bridge_leg_a <= 1'b0;
            o_bridge_leg_a_oe <= pins_ff.neg_leg_a;
            o_bridge_leg_b <= 1'b0;
            o_bridge_leg_b_oe <= pins_ff.neg_leg_b;
        end
    end

    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_fault_flag_pin <= 1'b0;
            o_fault_flag_pin_oe <= 1'b0;
        end else begin
            o_fault_flag_pin <= ~(off_req | latch_ff | hard_fault | pins_ff.under_volt);
            o_fault_flag_pin_oe <= ~pins_ff.mode_select_supply_pin;
        end
    end

    // Frame end handling.
    logic ss_rise;
    logic ss_fall;
    logic [3:0] busy_cnt_ff;
    logic collide_ff;
    logic frame_bad;
    logic diag_read_done;
    logic [7:0] diag_ff;
    assign ss_rise = pins_ff.ss_n & ~pins_d_ff.ss_n;
    assign ss_fall = ~pins_ff.ss_n & pins_d_ff.ss_n;
    assign frame_bad = (frame_ff.count != FRAME_BITS) | ~code_used(frame_ff.word[13:9]) | collide_ff;
    assign diag_read_done = ss_rise & frame_ff.addr_ok & ~frame_bad & (frame_ff.word[13:9] == INS_DIAG);

    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            busy_cnt_ff <= 4'h0;
        end else if (ss_rise) begin
            busy_cnt_ff <= PROC_CYC;
        end else if (busy_cnt_ff != 4'h0) begin
            busy_cnt_ff <= busy_cnt_ff - 4'h1;
        end
    end

    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            collide_ff <= 1'b0;
        end else if (ss_fall && busy_cnt_ff != 4'h0) begin
            collide_ff <= 1'b1;
        end else if (ss_rise) begin
            collide_ff <= 1'b0;
        end
    end

    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            prev_err_ff <= 1'b0;
        end else if (!pins_ff.mode_select_supply_pin) begin
            prev_err_ff <= 1'b0;
        end else if (ss_rise && frame_ff.addr_ok) begin
            prev_err_ff <= frame_bad;
        end
    end

    // Sticky fault bits read as zero; a new event wins over any reset except i_resetn.
    logic [7:0] diag_set_ones;
    logic [7:0] diag_base;
    always_comb begin
        diag_base = (diag_read_done | pins_ff.bridge_off_input | ~pins_ff.enable |
                     ~pins_ff.mode_select_supply_pin) ? DIAG_RESET : diag_ff;
        diag_set_ones = 8'h00;
        diag_set_ones[DIAG_OT_BIT] = pins_ff.over_temp;
        diag_set_ones[DIAG_CRED_BIT] = pins_ff.curr_reduce;
        diag_set_ones[DIAG_CLIM_BIT] = pins_ff.curr_limit;
    end

    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            diag_ff <= DIAG_RESET;
        end else begin
            diag_ff[DIAG_EN_BIT] <= ~off_req;
            diag_ff[6:4] <= diag_base[6:4] & ~diag_set_ones[6:4];
            diag_ff[3:0] <= pins_ff.under_volt ? 4'h0 : pins_ff.leg_diag;
        end
    end

    // Snapshot frozen while SS is low so the SPI side reads a steady byte.
    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            diag_hold_ff <= DIAG_RESET;
        end else if (pins_ff.ss_n) begin
            diag_hold_ff <= diag_ff;
        end
    end

endmodule

`default_nettype wire

// File: hbc_bridge_properties.sv
// Pin-level relations of the H-bridge block, checked on the system clock.
// Assumes the bench holds each pin level for several clocks at a time.
`timescale 1ns/10ps
`default_nettype none
module hbc_bridge_props
    import hbc_pkg::*;
(
    input wire logic i_mclk,
    input wire logic i_resetn,
    input wire logic i_ss_n,
    input wire logic i_mode_select_supply_pin,
    input wire logic i_bridge_off_input,
    input wire logic i_drive_a_input,
    input wire logic i_drive_b_input,
    input wire logic i_neg_leg_a,
    input wire logic i_over_current,
    input wire logic i_under_volt,
    input wire logic o_so_oe,
    input wire logic o_fault_flag_pin,
    input wire logic o_fault_flag_pin_oe,
    input wire logic o_bridge_leg_a,
    input wire logic o_bridge_leg_a_oe,
    input wire logic o_bridge_leg_b,
    input wire logic o_bridge_leg_b_oe
);
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_resetn);
    a_so_idle_off: assert property (i_ss_n && $past(i_ss_n) |-> !o_so_oe)
        else $error("serial out driven while deselected");
    a_so_mode_off: assert property (!i_mode_select_supply_pin [*2] |-> !o_so_oe)
        else $error("serial out driven in flag mode");
    a_flag_mode_on: assert property (!i_mode_select_supply_pin [*4] |-> o_fault_flag_pin_oe)
        else $error("flag not driven in flag mode");
    a_flag_mode_off: assert property (i_mode_select_supply_pin [*4] |-> !o_fault_flag_pin_oe)
        else $error("flag driven in serial mode");
    a_legs_off_disabled: assert property ((i_bridge_off_input && !i_neg_leg_a) [*4] |-> !o_bridge_leg_a_oe)
        else $error("leg a driven while disabled");
    a_free_wheel_low: assert property ((i_bridge_off_input && i_neg_leg_a) [*4]
        |-> o_bridge_leg_a_oe && !o_bridge_leg_a)
        else $error("free-wheel low side not on");
    a_overcurrent_flag: assert property (i_over_current [*4] |-> !o_fault_flag_pin)
        else $error("flag high during overcurrent");
    a_undervolt_flag: assert property (i_under_volt [*4] |-> !o_fault_flag_pin && !o_bridge_leg_b_oe)
        else $error("flag high or leg on during undervoltage");
    a_leg_b_low: assert property ((i_drive_a_input && !i_drive_b_input) [*4] ##0 o_bridge_leg_b_oe
        |-> !o_bridge_leg_b)
        else $error("leg b high in forward drive");
    a_leg_a_low: assert property ((!i_drive_a_input && i_drive_b_input) [*4] ##0 o_bridge_leg_a_oe
        |-> !o_bridge_leg_a)
        else $error("leg a high in reverse drive");
endmodule
bind hbc_bridge hbc_bridge_props chk_u (.i_mclk, .i_resetn, .i_ss_n, .i_mode_select_supply_pin,
    .i_bridge_off_input, .i_drive_a_input, .i_drive_b_input, .i_neg_leg_a, .i_over_current,
    .i_under_volt, .o_so_oe, .o_fault_flag_pin, .o_fault_flag_pin_oe, .o_bridge_leg_a,
    .o_bridge_leg_a_oe, .o_bridge_leg_b, .o_bridge_leg_b_oe);
`default_nettype wire

// File: hbc_spi_master.sv
// Behavioural serial master standing for the microcontroller.
// Its clock has a 32 ns period and runs only inside frames, idle low.
`timescale 1ns/10ps
`default_nettype none
module hbc_spi_master
    import hbc_pkg::*;
(
    input wire logic i_so,
    input wire logic i_so_oe,
    output logic o_sck,
    output logic o_ss_n,
    output logic o_si
);
    initial begin
        o_sck = 1'h0;
        o_ss_n = 1'h1;
        o_si = 1'h0;
    end
    task automatic xfer(input logic [15:0] w, input int n, output logic [15:0] rx, output logic [15:0] oe);
        o_ss_n = 1'h0;
        #210;
        for (int k = 0; k < n; k++) begin
            o_si = w[15 - (k % 16)];
            o_sck = 1'h1;
            #16;
            if (k < 16) begin
                rx[15 - k] = i_so;
                oe[15 - k] = i_so_oe;
            end
            o_sck = 1'h0;
            #16;
        end
        #160;
        o_ss_n = 1'h1;
        // Released data line must not keep its last level.
        o_si = ~o_si;
    endtask
endmodule
`default_nettype wire

// File: test_hbridge_control_diag_spi.sv
// Self-checking bench of the H-bridge block: bridge pins, then serial frames.
// Serial traffic comes from the master model; pins change 2 ns after a clock edge.
`timescale 1ns/10ps
`default_nettype none
module test_hbridge_control_diag_spi
    import hbc_pkg::*;
;
    localparam logic [7:0] ID_V = 8'hA6; // arbitrary value
    localparam logic [7:0] VER_V = 8'h3C; // arbitrary value
    logic i_mclk, i_resetn, i_sck, i_ss_n, i_si, o_so, o_so_oe, o_fault_flag_pin, o_fault_flag_pin_oe;
    logic o_bridge_leg_a, o_bridge_leg_a_oe, o_bridge_leg_b, o_bridge_leg_b_oe;
    hbc_pins_t p;
    logic [15:0] rx, oe;
    int n_mismatch, checks;
    hbc_bridge #(.IDENT_CODE(ID_V), .VERSION_CODE(VER_V)) dut_u (.i_mclk, .i_resetn, .i_sck, .i_ss_n, .i_si,
        .i_mode_select_supply_pin(p.mode_select_supply_pin), .i_bridge_off_input(p.bridge_off_input),
        .i_enable(p.enable), .i_drive_a_input(p.drive_a_input), .i_drive_b_input(p.drive_b_input),
        .i_off_float(p.off_float), .i_en_float(p.en_float), .i_short_fault(p.short_fault),
        .i_over_current(p.over_current), .i_over_temp(p.over_temp), .i_under_volt(p.under_volt),
        .i_curr_limit(p.curr_limit), .i_curr_reduce(p.curr_reduce), .i_neg_leg_a(p.neg_leg_a),
        .i_neg_leg_b(p.neg_leg_b), .i_leg_diag(p.leg_diag), .o_so, .o_so_oe, .o_fault_flag_pin,
        .o_fault_flag_pin_oe, .o_bridge_leg_a, .o_bridge_leg_a_oe, .o_bridge_leg_b, .o_bridge_leg_b_oe);
    hbc_spi_master mst_u (.i_so(o_so), .i_so_oe(o_so_oe), .o_sck(i_sck), .o_ss_n(i_ss_n), .o_si(i_si));
    initial begin
        i_mclk = 1'h0;
        forever #20 i_mclk = ~i_mclk;
    end
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
        checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge i_mclk);
        #2;
    endtask
    // Expected bits are leg a oe, leg b oe, leg a, leg b, flag.
    task automatic legs(input logic [4:0] e, input string what);
        step(4);
        chk({11'h000, o_bridge_leg_a_oe, o_bridge_leg_b_oe, o_bridge_leg_a, o_bridge_leg_b, o_fault_flag_pin},
            {11'h000, e}, what);
    endtask
    task automatic run(input logic [15:0] w, input int n, input int gap, input logic c, input logic on,
                       input logic err, input logic [7:0] d);
        mst_u.xfer(w, n, rx, oe);
        if (c) begin
            chk(oe, on ? 16'h3FFF : 16'h0000, "frame drive");
            if (on) begin
                chk(rx & 16'h3FFF, {2'h0, CHECK_PATTERN, err, d}, "frame data");
            end
        end
        #(gap);
        // Pin changes that follow a frame stay just after a system clock edge.
        step(1);
    endtask
    initial begin
        #1_000_000;
        n_mismatch++;
        $display("mismatch at %0t: run did not finish", $time);
        report_and_stop();
    end
    initial begin
        p = '0;
        p.enable = 1'h1;
        p.leg_diag = 4'h9;
        i_resetn = 1'h0;
        n_mismatch = 0;
        checks = 0;
        step(12);
        i_resetn = 1'h1;
        for (int k = 0; k < 4; k++) begin
            p.drive_a_input = k[1];
            p.drive_b_input = k[0];
            legs({2'h3, k[1:0], 1'h1}, "drive");
        end
        for (int k = 0; k < 4; k++) begin
            p.bridge_off_input = (k == 0);
            p.enable = (k != 1);
            p.off_float = (k == 2);
            p.en_float = (k == 3);
            legs(5'h00, "off cause");
            p = '{enable: 1'h1, drive_a_input: 1'h1, drive_b_input: 1'h1, leg_diag: 4'h9, default: 1'h0};
            legs(5'h1F, "back on");
        end
        p.bridge_off_input = 1'h1;
        p.neg_leg_a = 1'h1;
        legs(5'h10, "free wheel");
        p.neg_leg_a = 1'h0;
        legs(5'h00, "free wheel end");
        p.neg_leg_b = 1'h1;
        legs(5'h08, "free wheel b");
        p.neg_leg_b = 1'h0;
        p.bridge_off_input = 1'h0;
        for (int k = 0; k < 3; k++) begin
            {p.short_fault, p.over_current, p.over_temp} = 3'h4 >> k;
            legs(5'h00, "fault");
            {p.short_fault, p.over_current, p.over_temp} = 3'h0;
            legs(5'h00, "latched");
            p.bridge_off_input = k[0];
            p.enable = k[0];
            step(4);
            p.bridge_off_input = 1'h0;
            p.enable = 1'h1;
            legs(5'h1F, "cleared");
        end
        p.under_volt = 1'h1;
        legs(5'h00, "undervoltage");
        p.under_volt = 1'h0;
        legs(5'h1F, "recovered");
        p.curr_limit = 1'h1;
        step(1);
        p.curr_limit = 1'h0;
        legs(5'h01, "limit");
        step(int'(CL_OFF_CYC) - 20);
        legs(5'h01, "limit hold");
        step(40);
        legs(5'h1F, "limit end");
        $display("test bridge done");
        run(16'h0000, 16, 400, 1, 0, 0, 8'h00);
        p.mode_select_supply_pin = 1'h1;
        step(4);
        chk({15'h0000, o_fault_flag_pin_oe}, 16'h0000, "flag oe");
        run(16'h0000, 16, 400, 1, 1, 0, ID_V);
        run(16'h0200, 16, 400, 1, 1, 0, VER_V);
        run(16'h0400, 16, 400, 1, 1, 0, DATA_UNUSED);
        run(16'h4000, 16, 400, 1, 0, 0, 8'h00);
        run(16'h0000, 16, 400, 1, 1, 1, ID_V);
        run(16'h0000, 15, 400, 0, 0, 0, 8'h00);
        run(16'h0000, 17, 400, 1, 1, 1, ID_V);
        run(16'h02A5, 16, 90, 1, 1, 1, VER_V);
        run(16'h0000, 16, 400, 0, 0, 0, 8'h00);
        run(16'h0000, 16, 400, 1, 1, 1, ID_V);
        run(16'h0800, 16, 400, 1, 1, 0, 8'hF9);
        p.curr_reduce = 1'h1;
        step(2);
        p.curr_reduce = 1'h0;
        step(4);
        run(16'h0800, 16, 400, 1, 1, 0, 8'hD9);
        run(16'h0800, 16, 400, 1, 1, 0, 8'hF9);
        $display("test serial done");
        report_and_stop();
    end
endmodule
`default_nettype wire
